// ---- verilog/epc_cfg.svh ----
// Purpose: Constants for the exception priority and cause unit
// Assumes: 32-bit addresses, 5-bit cause field
// Notes: Vector addresses are plain defaults, overridden per build
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH
`define EPC_ADDR_W 32
`define EPC_CAUSE_W 5
`define EPC_LVL_W 6
`define EPC_STATUS_W 32
`define EPC_RST_IE_BIT 23
`define EPC_GLB_IE_BIT 0
`define EPC_LVL_LSB 10
`define EPC_CAUSE_RESET 5'h00
`define EPC_CAUSE_CPURST 5'h01
`define EPC_CAUSE_IRQ 5'h02
`define EPC_CAUSE_TRAP 5'h03
`define EPC_CAUSE_UNIMP 5'h04
`define EPC_CAUSE_ILLEGAL 5'h05
`define EPC_CAUSE_MISDATA 5'h06
`define EPC_CAUSE_MISDEST 5'h07
`define EPC_CAUSE_DIV 5'h08
`define EPC_CAUSE_SUPIADDR 5'h09
`define EPC_CAUSE_SUPINST 5'h0a
`define EPC_CAUSE_SUPDADDR 5'h0b
`define EPC_CAUSE_TLBMISS 5'h0c
`define EPC_CAUSE_PERMX 5'h0d
`define EPC_CAUSE_PERMR 5'h0e
`define EPC_CAUSE_PERMW 5'h0f
`define EPC_CAUSE_MPUI 5'h10
`define EPC_CAUSE_MPUD 5'h11
`define EPC_CAUSE_ECCTLB 5'h12
`define EPC_CAUSE_ECCRF 5'h14
`define EPC_RET_OFS 32'h0000_0004
`define EPC_RESET_VEC 32'h0000_0000
`define EPC_BREAK_VEC 32'h0000_0020
`define EPC_GEN_VEC 32'h0000_0040
`define EPC_FTLB_VEC 32'h0000_0060
`endif

// ---- verilog/epc_pkg.sv ----
// Purpose: Types for the exception priority and cause unit
// Assumes: epc_cfg.svh provides widths
// Notes: Pending conditions travel as one packed struct
`include "epc_cfg.svh"
package epc_pkg;
    typedef enum logic [4:0] {
        EPC_VK_NONE = 5'b00001,
        EPC_VK_RESET = 5'b00010,
        EPC_VK_BREAK = 5'b00100,
        EPC_VK_GEN = 5'b01000,
        EPC_VK_FTLB = 5'b10000
    } epc_vkind_e;
    // Vector kind for the requested handler address is separate from one-hot set above
    typedef struct packed {
        logic fullReset;
        logic hwBreak;
        logic cpuReset;
        logic intIrq;
        logic extNmi;
        logic extIrq;
        logic eccTlbInst;
        logic supInstAddr;
        logic tlbMissInst;
        logic permExec;
        logic eccRegFile;
        logic mpuInst;
        logic supInst;
        logic trapInst;
        logic illegalInst;
        logic unimpInst;
        logic breakInst;
        logic supDataAddr;
        logic misData;
        logic misDest;
        logic eccTlbData;
        logic divError;
        logic tlbMissData;
        logic permRead;
        logic permWrite;
        logic mpuData;
    } epc_pend_s;
    typedef struct packed {
        logic take;
        logic useReqHandler;
        logic writeCause;
        logic [`EPC_CAUSE_W-1:0] cause;
        logic [`EPC_ADDR_W-1:0] vector;
        logic writeBad;
        logic writeVpn;
        logic [`EPC_ADDR_W-1:0] recAddr;
        logic flush;
        logic toBreak;
        logic [`EPC_STATUS_W-1:0] status;
        logic [`EPC_STATUS_W-1:0] bstatus;
        logic [`EPC_ADDR_W-1:0] breakRet;
        logic [`EPC_CAUSE_W-1:0] causeField;
        logic [`EPC_ADDR_W-1:0] badAddr;
        logic [`EPC_ADDR_W-1:0] vpnAddr;
        logic excActive;
        logic rstLine;
    } epc_state_s;
endpackage : epc_pkg

// ---- verilog/epc_unit.sv ----
// Purpose: Rank pending exceptions, pick one vector, write cause and addresses
// Assumes: Pipeline presents conditions for the oldest instruction only
// Notes: Outputs are registered, one take per cycle at most
`timescale 1ns/1ns
`default_nettype none
`include "epc_cfg.svh"
// Overview of operation
// - Flush younger work on every take so the faulting instruction can rerun
// - Take only the highest ranked pending exception by fixed order
// - Resets go to reset vector; full reset cause 0, processor reset cause 1
// - Breaks go to break vector, no cause; break instruction records ba minus 4
// - Instruction exceptions use general vector except fast TLB misses and the break instruction
// - Write the cause value of the taken exception when it has one
// - Internal interrupt writes cause 2, records return minus 4, general vector
// - External maskable writes cause 2, nonmaskable none; both use handler address
// - Global enable masks internal and maskable external interrupts only
// - TLB ECC error writes 18; data case records bad data address
// - Register file ECC error writes 20, return minus 4, general vector
// - TLB miss 12, permission 13/14/15, record virtual page number
// - First level TLB miss vectors to fast TLB miss address
// - TLB miss during exception handling is double miss to general vector
// - MPU violations write 16 instruction, 17 data with bad address
// - Supervisor violations: 9 instruction address, 11 data, 10 instruction
// - Trap 3, unimplemented 4, illegal 5 when detection or MMU/MPU
// - Misaligned data 6, destination 7 when enabled, address to bad register
// - Division error writes 8 when enabled, return minus 4, general vector
// - Every take selects exactly one vector address
// - Reset sets reset enable bit, clears other status, invalidates line
// - Break saves status, clears global enable, saves return address
// - Maskable external taken only when requested level exceeds current level
module epc_unit #(
    parameter bit HAS_MMU = 1'b1,
    parameter bit HAS_MPU = 1'b0,
    parameter bit HAS_ECC = 1'b1,
    parameter bit HAS_EXT_CTRL = 1'b1,
    parameter bit ILLEGAL_DET = 1'b1,
    parameter bit MISALIGN_DET = 1'b1,
    parameter bit DIV_DET = 1'b1,
    parameter logic [`EPC_ADDR_W-1:0] RESET_VEC = `EPC_RESET_VEC,
    parameter logic [`EPC_ADDR_W-1:0] BREAK_VEC = `EPC_BREAK_VEC,
    parameter logic [`EPC_ADDR_W-1:0] GEN_VEC = `EPC_GEN_VEC,
    parameter logic [`EPC_ADDR_W-1:0] FTLB_VEC = `EPC_FTLB_VEC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire epc_pkg::epc_pend_s pend,
    input wire logic [`EPC_ADDR_W-1:0] exception_return_addr,
    input wire logic [`EPC_ADDR_W-1:0] nextInstAddr,
    input wire logic [`EPC_ADDR_W-1:0] dataAddr,
    input wire logic [`EPC_ADDR_W-1:0] destAddr,
    input wire logic [`EPC_ADDR_W-1:0] fetchAddr,
    input wire logic [`EPC_ADDR_W-1:0] requested_handler_addr,
    input wire logic [`EPC_LVL_W-1:0] requested_irq_level,
    input wire logic [`EPC_STATUS_W-1:0] statusWrData,
    input wire logic statusWrEn,
    output logic takeValid,
    output logic [`EPC_ADDR_W-1:0] vectorAddr,
    output logic flushPipe,
    output logic causeWrite,
    output logic [`EPC_CAUSE_W-1:0] causeCode,
    output logic [`EPC_CAUSE_W-1:0] causeField,
    output logic [`EPC_ADDR_W-1:0] recordedAddr,
    output logic [`EPC_ADDR_W-1:0] badAddr,
    output logic [`EPC_ADDR_W-1:0] page_table_virtual_page,
    output logic [`EPC_STATUS_W-1:0] statusReg,
    output logic [`EPC_STATUS_W-1:0] breakStatus,
    output logic [`EPC_ADDR_W-1:0] breakReturn,
    output logic invalidateResetLine
);
    import epc_pkg::*;

    // ----------------------------------------
    // Qualification of pending conditions
    // ----------------------------------------
    epc_state_s cur_ff;
    epc_state_s nxt_cur;
    epc_pend_s q;
    logic global_irq_enable_bit;
    logic [`EPC_LVL_W-1:0] current_irq_level;
    logic [`EPC_ADDR_W-1:0] retMinus4;
    logic memChk;
    logic resetTake;

    assign global_irq_enable_bit = cur_ff.status[`EPC_GLB_IE_BIT];
    assign current_irq_level = cur_ff.status[`EPC_LVL_LSB +: `EPC_LVL_W];
    assign retMinus4 = exception_return_addr - `EPC_RET_OFS;
    assign memChk = HAS_MMU | HAS_MPU;
    // A processor reset loses to a hardware break, so it must not wipe status then
    assign resetTake = q.fullReset | (q.cpuReset & ~q.hwBreak);

    // Gate each request by its option; absent options cost no logic
    always_comb
    begin
        q = pend;
        q.intIrq = pend.intIrq & ~HAS_EXT_CTRL & global_irq_enable_bit;
        q.extNmi = pend.extNmi & HAS_EXT_CTRL;
        q.extIrq = pend.extIrq & HAS_EXT_CTRL & global_irq_enable_bit
            & (requested_irq_level > current_irq_level);
        q.eccTlbInst = pend.eccTlbInst & HAS_MMU & HAS_ECC;
        q.eccTlbData = pend.eccTlbData & HAS_MMU & HAS_ECC;
        q.eccRegFile = pend.eccRegFile & HAS_ECC;
        q.supInstAddr = pend.supInstAddr & HAS_MMU;
        q.supDataAddr = pend.supDataAddr & HAS_MMU;
        q.tlbMissInst = pend.tlbMissInst & HAS_MMU;
        q.tlbMissData = pend.tlbMissData & HAS_MMU;
        q.permExec = pend.permExec & HAS_MMU;
        q.permRead = pend.permRead & HAS_MMU;
        q.permWrite = pend.permWrite & HAS_MMU;
        q.mpuInst = pend.mpuInst & HAS_MPU;
        q.mpuData = pend.mpuData & HAS_MPU;
        q.supInst = pend.supInst & memChk;
        q.illegalInst = pend.illegalInst & (ILLEGAL_DET | memChk);
        q.misData = pend.misData & (MISALIGN_DET | memChk);
        q.misDest = pend.misDest & (MISALIGN_DET | memChk);
        q.divError = pend.divError & DIV_DET;
    end

    // ----------------------------------------
    // Priority selection and state update
    // ----------------------------------------
    // The if chain order is the ranking; first match wins and the rest record nothing
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.take = 1'b1;
        nxt_cur.useReqHandler = 1'b0;
        nxt_cur.writeCause = 1'b1;
        nxt_cur.cause = `EPC_CAUSE_RESET;
        nxt_cur.vector = GEN_VEC;
        nxt_cur.writeBad = 1'b0;
        nxt_cur.writeVpn = 1'b0;
        nxt_cur.recAddr = retMinus4;
        nxt_cur.toBreak = 1'b0;
        nxt_cur.flush = 1'b1;
        if (q.fullReset)
        begin
            nxt_cur.vector = RESET_VEC;
        end
        else if (q.hwBreak)
        begin
            nxt_cur.vector = BREAK_VEC;
            nxt_cur.writeCause = 1'b0;
            nxt_cur.toBreak = 1'b1;
            nxt_cur.recAddr = nextInstAddr;
        end
        else if (q.cpuReset)
        begin
            nxt_cur.vector = RESET_VEC;
            nxt_cur.cause = `EPC_CAUSE_CPURST;
        end
        else if (q.intIrq)
        begin
            nxt_cur.cause = `EPC_CAUSE_IRQ;
        end
        else if (q.extNmi)
        begin
            nxt_cur.useReqHandler = 1'b1;
            nxt_cur.writeCause = 1'b0;
            nxt_cur.vector = requested_handler_addr;
        end
        else if (q.extIrq)
        begin
            nxt_cur.useReqHandler = 1'b1;
            nxt_cur.cause = `EPC_CAUSE_IRQ;
            nxt_cur.vector = requested_handler_addr;
        end
        else if (q.eccTlbInst)
            nxt_cur.cause = `EPC_CAUSE_ECCTLB;
        else if (q.supInstAddr)
            nxt_cur.cause = `EPC_CAUSE_SUPIADDR;
        else if (q.tlbMissInst)
        begin
            nxt_cur.cause = `EPC_CAUSE_TLBMISS;
            nxt_cur.writeVpn = 1'b1;
            nxt_cur.vector = cur_ff.excActive ? GEN_VEC : FTLB_VEC;
        end
        else if (q.permExec)
        begin
            nxt_cur.cause = `EPC_CAUSE_PERMX;
            nxt_cur.writeVpn = 1'b1;
        end
        else if (q.eccRegFile)
            nxt_cur.cause = `EPC_CAUSE_ECCRF;
        else if (q.mpuInst)
            nxt_cur.cause = `EPC_CAUSE_MPUI;
        else if (q.supInst)
            nxt_cur.cause = `EPC_CAUSE_SUPINST;
        else if (q.trapInst)
            nxt_cur.cause = `EPC_CAUSE_TRAP;
        else if (q.illegalInst)
            nxt_cur.cause = `EPC_CAUSE_ILLEGAL;
        else if (q.unimpInst)
            nxt_cur.cause = `EPC_CAUSE_UNIMP;
        else if (q.breakInst)
        begin
            nxt_cur.vector = BREAK_VEC;
            nxt_cur.writeCause = 1'b0;
            nxt_cur.toBreak = 1'b1;
            nxt_cur.recAddr = nextInstAddr - `EPC_RET_OFS;
        end
        else if (q.supDataAddr)
        begin
            nxt_cur.cause = `EPC_CAUSE_SUPDADDR;
            nxt_cur.writeBad = 1'b1;
        end
        else if (q.misData)
        begin
            nxt_cur.cause = `EPC_CAUSE_MISDATA;
            nxt_cur.writeBad = 1'b1;
        end
        else if (q.misDest)
        begin
            nxt_cur.cause = `EPC_CAUSE_MISDEST;
            nxt_cur.writeBad = 1'b1;
        end
        else if (q.eccTlbData)
        begin
            nxt_cur.cause = `EPC_CAUSE_ECCTLB;
            nxt_cur.writeBad = 1'b1;
        end
        else if (q.divError)
            nxt_cur.cause = `EPC_CAUSE_DIV;
        else if (q.tlbMissData)
        begin
            nxt_cur.cause = `EPC_CAUSE_TLBMISS;
            nxt_cur.writeBad = 1'b1;
            nxt_cur.writeVpn = 1'b1;
            nxt_cur.vector = cur_ff.excActive ? GEN_VEC : FTLB_VEC;
        end
        else if (q.permRead)
        begin
            nxt_cur.cause = `EPC_CAUSE_PERMR;
            nxt_cur.writeBad = 1'b1;
            nxt_cur.writeVpn = 1'b1;
        end
        else if (q.permWrite)
        begin
            nxt_cur.cause = `EPC_CAUSE_PERMW;
            nxt_cur.writeBad = 1'b1;
            nxt_cur.writeVpn = 1'b1;
        end
        else if (q.mpuData)
        begin
            nxt_cur.cause = `EPC_CAUSE_MPUD;
            nxt_cur.writeBad = 1'b1;
        end
        else
        begin
            nxt_cur.take = 1'b0;
            nxt_cur.writeCause = 1'b0;
            nxt_cur.flush = 1'b0;
            nxt_cur.vector = cur_ff.vector;
            nxt_cur.recAddr = cur_ff.recAddr;
        end
        // Software status writes first, so a same-cycle take still clears global enable and a reset overrides them
        if (statusWrEn)
            nxt_cur.status = statusWrData;
        if (nxt_cur.writeCause)
            nxt_cur.causeField = nxt_cur.cause;
        if (nxt_cur.writeBad)
            nxt_cur.badAddr = nxt_cur.cause == `EPC_CAUSE_MISDEST ? destAddr : dataAddr;
        if (nxt_cur.writeVpn)
            nxt_cur.vpnAddr = nxt_cur.writeBad ? dataAddr : fetchAddr;
        if (nxt_cur.toBreak)
        begin
            nxt_cur.bstatus = cur_ff.status;
            nxt_cur.status[`EPC_GLB_IE_BIT] = 1'b0;
            nxt_cur.breakRet = nextInstAddr;
        end
        else if (nxt_cur.take)
        begin
            nxt_cur.status[`EPC_GLB_IE_BIT] = 1'b0;
            nxt_cur.excActive = HAS_MMU;
        end
        // Exception-active clears only by a software status write without a take, or by a reset
        if (statusWrEn && !nxt_cur.take)
            nxt_cur.excActive = 1'b0;
        // Registered so the invalidate strobe leaves straight from a flop
        nxt_cur.rstLine = resetTake;
        if (resetTake)
        begin
            nxt_cur.status = '0;
            nxt_cur.status[`EPC_RST_IE_BIT] = 1'b1;
            nxt_cur.excActive = 1'b0;
        end
    end

    // Async reset loads reset-handler state; rstLine marks line invalidation
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_ff <= '0;
            cur_ff.status[`EPC_RST_IE_BIT] <= 1'b1;
            cur_ff.vector <= RESET_VEC;
            cur_ff.take <= 1'b1;
            cur_ff.flush <= 1'b1;
            cur_ff.writeCause <= 1'b1;
            cur_ff.rstLine <= 1'b1;
        end
        else
            cur_ff <= nxt_cur;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign takeValid = cur_ff.take;
    assign vectorAddr = cur_ff.vector;
    assign flushPipe = cur_ff.flush;
    assign causeWrite = cur_ff.writeCause;
    assign causeCode = cur_ff.cause;
    assign causeField = cur_ff.causeField;
    assign recordedAddr = cur_ff.recAddr;
    assign badAddr = cur_ff.badAddr;
    assign page_table_virtual_page = cur_ff.vpnAddr;
    assign statusReg = cur_ff.status;
    assign breakStatus = cur_ff.bstatus;
    assign breakReturn = cur_ff.breakRet;
    assign invalidateResetLine = cur_ff.rstLine;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence resetSeen;
        pend.fullReset;
    endsequence
    full_reset_vec_a: assert property (@(posedge clock) disable iff (!rst_n)
        resetSeen |=> takeValid && vectorAddr == RESET_VEC && causeField == 5'h00)
        else $error("full reset not taken to reset vector");
    cpu_reset_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
        pend.cpuReset && !pend.fullReset && !pend.hwBreak |=> causeField == 5'h01
        && invalidateResetLine)
        else $error("processor reset cause wrong");
    break_no_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
        pend.hwBreak && !pend.fullReset |=> vectorAddr == BREAK_VEC
        && $stable(causeField) && !statusReg[`EPC_GLB_IE_BIT] && !invalidateResetLine)
        else $error("break changed cause or vector");
    irq_masked_a: assert property (@(posedge clock) disable iff (!rst_n)
        !global_irq_enable_bit && !(|{pend[25:23], pend[21], pend[19:0]}) |=> !takeValid)
        else $error("masked interrupt taken");
    nmi_handler_a: assert property (@(posedge clock) disable iff (!rst_n)
        HAS_EXT_CTRL && pend.extNmi && !pend.fullReset && !pend.hwBreak && !pend.cpuReset
        && !q.intIrq |=> vectorAddr == $past(requested_handler_addr)
        && $stable(causeField))
        else $error("nonmaskable interrupt misrouted");
    ext_level_a: assert property (@(posedge clock) disable iff (!rst_n)
        pend.extIrq && requested_irq_level <= current_irq_level
        && !(|{pend[25:21], pend[19:0]}) |=> !takeValid)
        else $error("maskable interrupt taken at or below current level");
    ftlb_vec_a: assert property (@(posedge clock) disable iff (!rst_n)
        takeValid && causeCode == 5'h0c && vectorAddr == FTLB_VEC |->
        !$past(cur_ff.excActive))
        else $error("fast miss taken during exception");
    idle_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
        !takeValid |-> !causeWrite && !flushPipe)
        else $error("state recorded without a take");
endmodule : epc_unit
`default_nettype wire

// ---- test/epc_far_model.sv ----
// Purpose: Far side model: external interrupt controller, debug module, reset sources
// Assumes: Bench commands change at the falling edge of the clock
// Notes: Released request fields toggle each cycle so a stale value never matches
`timescale 1ns/1ns
`default_nettype none
module epc_far_model (
    input wire logic clock,
    input wire logic [4:0] farCmd,
    input wire logic [31:0] cmdHandler,
    input wire logic [5:0] cmdLevel,
    output logic [4:0] farPend,
    output logic [31:0] reqHandler,
    output logic [5:0] reqLevel
);
    logic [31:0] lastHandler = 32'h0000_0000;
    logic [5:0] lastLevel = 6'h00;
    logic irqOn;
    // ----------------------------------------
    // Request lines
    // ----------------------------------------
    // Order: full reset, hw break, cpu reset, nonmaskable, maskable
    assign farPend = farCmd;
    assign irqOn = farCmd[1] | farCmd[0];
    // Idle fields show the inverse of the last value, never a held one
    assign reqHandler = irqOn ? cmdHandler : ~lastHandler;
    assign reqLevel = irqOn ? cmdLevel : ~lastLevel;
    // Remember what was shown for the idle pattern
    always_ff @(posedge clock)
    begin
        lastHandler <= reqHandler;
        lastLevel <= reqLevel;
    end
endmodule : epc_far_model
`default_nettype wire

// ---- test/epc_unit_tb_top.sv ----
// Purpose: Self-checking bench for the exception priority and cause unit
// Assumes: Default build: MMU, ECC, external controller, no MPU
// Notes: Each take is presented for one cycle and judged after it lands
`timescale 1ns/1ns
`default_nettype none
`include "epc_cfg.svh"
module epc_unit_tb_top;
    import epc_pkg::*;
    logic clock, rst_n, statusWrEn, takeValid, flushPipe, causeWrite, invalLine;
    logic [4:0] farCmd, farPend, causeCode, causeField;
    logic [5:0] cmdLevel, reqLevel;
    logic [31:0] retAddr, nextAddr, dAddr, dstAddr, cmdHandler, reqHandler, statusWrData;
    logic [31:0] vectorAddr, recAddr, badAddr, pageVpn, statusReg, breakStatus, breakReturn;
    epc_pend_s pendSw, pend;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    // ----------------------------------------
    // Clock, far side and unit
    // ----------------------------------------
    initial
    begin
        clock = 1'h0;
        forever #2 clock = ~clock;
    end
    // Far side owns the reset, break and external interrupt bits
    always_comb
    begin
        pend = pendSw;
        {pend.fullReset, pend.hwBreak, pend.cpuReset, pend.extNmi, pend.extIrq} = farPend;
    end
    epc_far_model far (.clock(clock), .farCmd(farCmd), .cmdHandler(cmdHandler),
        .cmdLevel(cmdLevel), .farPend(farPend), .reqHandler(reqHandler), .reqLevel(reqLevel));
    epc_unit dut (.clock(clock), .rst_n(rst_n), .pend(pend), .exception_return_addr(retAddr),
        .nextInstAddr(nextAddr), .dataAddr(dAddr), .destAddr(dstAddr),
        .fetchAddr(32'h0000_3000), .requested_handler_addr(reqHandler),
        .requested_irq_level(reqLevel),
        .statusWrData(statusWrData), .statusWrEn(statusWrEn), .takeValid(takeValid),
        .vectorAddr(vectorAddr), .flushPipe(flushPipe), .causeWrite(causeWrite),
        .causeCode(causeCode), .causeField(causeField), .recordedAddr(recAddr),
        .badAddr(badAddr), .page_table_virtual_page(pageVpn), .statusReg(statusReg),
        .breakStatus(breakStatus), .breakReturn(breakReturn), .invalidateResetLine(invalLine));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // One idle cycle first so a strobe is never lowered and raised in one step
    task automatic fire(input logic [25:0] bits, input logic [4:0] cmd);
        @(negedge clock);
        pendSw = epc_pend_s'(bits);
        farCmd = cmd;
        @(negedge clock);
        pendSw = '0;
        farCmd = 5'h00;
    endtask : fire
    task automatic setStatus(input logic [31:0] v);
        @(negedge clock);
        statusWrData = v;
        statusWrEn = 1'h1;
        @(negedge clock);
        statusWrEn = 1'h0;
    endtask : setStatus
    task automatic expTake(input logic [31:0] vec, input logic wr, input logic [4:0] code,
        input logic [4:0] field);
        chk(takeValid, 1'h1, "take");
        chk(flushPipe, 1'h1, "flush");
        chk(vectorAddr, vec, "vector");
        chk(causeWrite, wr, "cause write");
        if (wr)
        begin
            chk(causeCode, code, "cause code");
        end
        chk(causeField, field, "cause field");
    endtask : expTake
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        expTake(`EPC_RESET_VEC, 1'h1, 5'h00, 5'h00);
        chk(statusReg, 32'h0080_0000, "reset status");
        chk(invalLine, 1'h1, "reset line");
        rst_n = 1'h1;
        @(negedge clock);
        chk(takeValid, 1'h0, "idle");
        $display("test_reset done");
    endtask : test_reset
    // Fifteen general vector conditions, each with every lower ranked bit also pending
    task automatic test_causes();
        logic [4:0] pos [15] = '{5'h07, 5'h0c, 5'h0b, 5'h0a, 5'h06, 5'h04, 5'h12, 5'h0d,
            5'h08, 5'h10, 5'h02, 5'h01, 5'h13, 5'h05, 5'h0f};
        logic [4:0] code [15] = '{5'h06, 5'h03, 5'h05, 5'h04, 5'h07, 5'h08, 5'h09, 5'h0a,
            5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h12, 5'h12, 5'h14};
        logic [14:0] isData = 15'h2d01;
        logic [31:0] badExp;
        for (int i = 0; i < 15; i++)
        begin
            dAddr = 32'h1000_0000 + 32'h0000_0010 * i;
            dstAddr = 32'h2000_0000 + 32'h0000_0010 * i;
            retAddr = 32'h0000_4000 + 32'h0000_0010 * i;
            fire((26'h000_0001 << (pos[i] + 5'h01)) - 26'h000_0001, 5'h00);
            expTake(`EPC_GEN_VEC, 1'h1, code[i], code[i]);
            if (isData[i])
            begin
                badExp = dAddr;
            end
            else if (i == 4)
            begin
                badExp = dstAddr;
            end
            else
            begin
                chk(recAddr, retAddr - 32'h0000_0004, "return minus 4");
            end
            chk(badAddr, badExp, "bad address");
        end
        // No MPU and no internal controller in this build
        fire(26'h040_4001, 5'h00);
        chk(takeValid, 1'h0, "absent option");
        $display("test_causes done");
    endtask : test_causes
    task automatic test_tlb();
        setStatus(32'h0000_0000);
        fire(26'h002_0000, 5'h00);
        expTake(`EPC_FTLB_VEC, 1'h1, 5'h0c, 5'h0c);
        chk(pageVpn, 32'h0000_3000, "fetch page");
        fire(26'h000_0008, 5'h00);
        expTake(`EPC_GEN_VEC, 1'h1, 5'h0c, 5'h0c);
        chk(badAddr, dAddr, "miss bad");
        chk(pageVpn, dAddr, "data page");
        @(negedge clock);
        chk(takeValid, 1'h0, "one pulse");
        $display("test_tlb done");
    endtask : test_tlb
    task automatic test_irq();
        cmdHandler = 32'h0000_8000;
        setStatus(32'h0000_1401);
        cmdLevel = 6'h05;
        fire(26'h000_0000, 5'h01);
        chk(takeValid, 1'h0, "level equal");
        cmdLevel = 6'h06;
        fire(26'h000_0000, 5'h01);
        expTake(32'h0000_8000, 1'h1, 5'h02, 5'h02);
        chk(recAddr, retAddr - 32'h0000_0004, "irq return");
        setStatus(32'h0000_0000);
        cmdLevel = 6'h3f;
        fire(26'h000_0000, 5'h01);
        chk(takeValid, 1'h0, "masked");
        cmdHandler = 32'h0000_8800;
        fire(26'h000_1000, 5'h02);
        expTake(32'h0000_8800, 1'h0, 5'h00, 5'h02);
        $display("test_irq done");
    endtask : test_irq
    task automatic test_break();
        nextAddr = 32'h0000_9000;
        setStatus(32'h0000_1401);
        fire(26'h000_1000, 5'h08);
        expTake(`EPC_BREAK_VEC, 1'h0, 5'h00, 5'h02);
        chk(breakStatus, 32'h0000_1401, "saved status");
        chk(statusReg[0], 1'h0, "enable cleared");
        chk(breakReturn, nextAddr, "break return");
        fire(26'h000_0200, 5'h00);
        expTake(`EPC_BREAK_VEC, 1'h0, 5'h00, 5'h02);
        chk(recAddr, nextAddr - 32'h0000_0004, "ba minus 4");
        chk(breakReturn, nextAddr, "instr break return");
        fire(26'h000_1000, 5'h06);
        expTake(`EPC_RESET_VEC, 1'h1, 5'h01, 5'h01);
        chk(statusReg, 32'h0080_0000, "cpu reset status");
        chk(invalLine, 1'h1, "cpu reset line");
        setStatus(32'h0000_1401);
        fire(26'h000_0000, 5'h0c);
        expTake(`EPC_BREAK_VEC, 1'h0, 5'h00, 5'h01);
        chk(statusReg, 32'h0000_1400, "break over cpu reset");
        chk(invalLine, 1'h0, "no line on break");
        fire(26'h000_0000, 5'h18);
        expTake(`EPC_RESET_VEC, 1'h1, 5'h00, 5'h00);
        $display("test_break done");
    endtask : test_break
    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial
    begin
        rst_n = 1'h0;
        pendSw = '0;
        farCmd = 5'h00;
        cmdHandler = 32'h0000_0000;
        cmdLevel = 6'h00;
        retAddr = 32'h0000_4000;
        nextAddr = 32'h0000_9000;
        dAddr = 32'h1000_0000;
        dstAddr = 32'h2000_0000;
        statusWrData = 32'h0000_0000;
        statusWrEn = 1'h0;
        repeat (20) @(negedge clock);
        test_reset();
        test_causes();
        test_tlb();
        test_irq();
        test_break();
        finish_test();
    end
    // Whole run needs under a hundred cycles; a hang counts as a mismatch
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            finish_test();
        end
    end
endmodule : epc_unit_tb_top
`default_nettype wire
